// file: seg_ctrl.sv
// Status, event, interrupt and pin configuration logic
`default_nettype none
// Notes on behaviour
// - Status reads return live signal values
// - Ramp ready reads low while rail ramps
// - Overcurrent status high while limit hit
// - Thermal flags high while thresholds reached
// - Power good high while rail in range
// - Fault onset or pin activation sets event flag
// - Unmasked set event asserts interrupt
// - Writing read value clears exactly those flags
// - Events during clear held, posted afterwards
// - Input events: supply low, pins 4..0
// - Fault events: overcurrent, thermal, range loss
// - Mask bits suppress matching event interrupts
// - Overcurrent masks also block event recording
// - Lock bit blocks writes 0xD0 to 0x14F
// - Slew code sets 10mV step interval
// - Debounce code selects input filter time
// - Mode bit: filter on or active output
// - Polarity bit: 0 active low, 1 high
// - IO pin function: input, open drain, push pull
// - Pin 0 function: input or tracking enable
module seg_ctrl
	import seg_pkg::*;
#(
	parameter int DEB_TICK_CYCLES = DEB_TICK_CYC
)(
	// Clock, reset, enable
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	// Register port
	input  wire logic [8:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	output logic            reg_rvalid_o,
	// Writes passed on to the lockable range
	output logic            locked_wr_o,
	output logic      [8:0] locked_addr_o,
	output logic      [7:0] locked_wdata_o,
	// Pins
	input  wire logic       input_pin_0_i,
	input  wire logic       input_pin_1_i,
	input  wire logic       io_pin_2_i,
	input  wire logic       io_pin_3_i,
	input  wire logic       input_pin_4_i,
	output logic            io_pin_2_o,
	output logic            io_pin_2_oe_n_o,
	output logic            io_pin_3_o,
	output logic            io_pin_3_oe_n_o,
	output logic            track_enable_o,
	// Monitored signals from the regulator core
	input  wire logic       io_supply_undervoltage_i,
	input  wire logic       rail_a_ramping_i,
	input  wire logic       rail_b_ramping_i,
	input  wire logic       rail_a_overcurrent_i,
	input  wire logic       rail_b_overcurrent_i,
	input  wire logic       thermal_shutdown_flag_i,
	input  wire logic       thermal_warning_i,
	input  wire logic       rail_a_in_range_i,
	input  wire logic       rail_b_in_range_i,
	// Ramp step pulses
	output logic            rail_a_step_o,
	output logic            rail_b_step_o,
	// Interrupt
	output logic            interrupt_out_n_o
);
	logic [7:0]  in_mask, flt_mask, ctrl, cfg01, cfg23, cfg4;
	logic [7:0]  in_evt, flt_evt, in_hold, flt_hold;
	logic [7:0]  mon_live, mon_prev, new_in, new_flt;
	logic [4:0]  pin_raw, pin_mode, pin_pol, filt_on, lvl, act, act_prev;
	logic [1:0]  fn2, fn3, rail_ramp, rail_step;
	logic [1:0]  slew_code [2];
	logic        uv_prev, wr_en, clr_in, clr_flt, in_lock, irq_any, tick;
	logic        v2, v3;
	logic [23:0] tick_cnt;
	logic [13:0] deb_lim;

	function automatic logic [13:0] deb_ticks(input logic [2:0] c);
		case (c)
			3'h1:    deb_ticks = DEB_K1;
			3'h2:    deb_ticks = DEB_K2;
			3'h3:    deb_ticks = DEB_K3;
			3'h4:    deb_ticks = DEB_K4;
			3'h5:    deb_ticks = DEB_K5;
			3'h6:    deb_ticks = DEB_K6;
			3'h7:    deb_ticks = DEB_K7;
			default: deb_ticks = DEB_K1;
		endcase
	endfunction

	function automatic logic [9:0] slew_cyc(input logic [1:0] c);
		case (c)
			2'h0:    slew_cyc = SLEW_C0;
			2'h1:    slew_cyc = SLEW_C1;
			2'h2:    slew_cyc = SLEW_C2;
			default: slew_cyc = SLEW_C3;
		endcase
	endfunction

	// Bus decode
	assign wr_en   = ce_i & reg_wr_i;
	assign clr_in  = wr_en & (reg_addr_i == ADR_IN_EVT);
	assign clr_flt = wr_en & (reg_addr_i == ADR_FLT_EVT);
	assign in_lock = (reg_addr_i >= ADR_LOCK_LO) && (reg_addr_i <= ADR_LOCK_HI);

	// Software written configuration
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			in_mask  <= RST_REG;
			flt_mask <= RST_REG;
			ctrl     <= RST_REG;
			cfg01    <= RST_REG;
			cfg23    <= RST_REG;
			cfg4     <= RST_REG;
		end
		else if (wr_en)
		begin
			case (reg_addr_i)
				ADR_IN_MASK:  in_mask  <= reg_wdata_i & VLD_IN_EVT;
				ADR_FLT_MASK: flt_mask <= reg_wdata_i & VLD_FLT_EVT;
				ADR_CTRL:     ctrl     <= reg_wdata_i;
				ADR_CFG01:    cfg01    <= reg_wdata_i;
				ADR_CFG23:    cfg23    <= reg_wdata_i;
				ADR_CFG4:     cfg4     <= reg_wdata_i & VLD_CFG4;
				default:      ctrl     <= ctrl;
			endcase
		end
	end

	// Locked range: the write is simply not forwarded while locked
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			locked_wr_o    <= 1'b0;
			locked_addr_o  <= 9'h000;
			locked_wdata_o <= 8'h00;
		end
		else if (ce_i)
		begin
			locked_wr_o    <= wr_en & in_lock & ~ctrl[CTRL_LOCK];
			locked_addr_o  <= reg_addr_i;
			locked_wdata_o <= reg_wdata_i;
		end
	end

	// Per pin settings; output-configured IO pins never filter
	assign fn2      = cfg23[CFG_FN_L +: 2];
	assign fn3      = cfg23[CFG_FN_H +: 2];
	assign pin_raw  = {input_pin_4_i, io_pin_3_i, io_pin_2_i,
	                   input_pin_1_i, input_pin_0_i};
	assign pin_mode = {cfg4[CFG_MODE_L], cfg23[CFG_MODE_H],
	                   cfg23[CFG_MODE_L], cfg01[CFG_MODE_H],
	                   cfg01[CFG_MODE_L]};
	assign pin_pol  = {cfg4[CFG_POL_L], cfg23[CFG_POL_H], cfg23[CFG_POL_L],
	                   cfg01[CFG_POL_H], cfg01[CFG_POL_L]};
	assign filt_on  = pin_mode & {1'b1, fn3 == FN_IN, fn2 == FN_IN, 2'b11}
	                  & {5{ctrl[CTRL_DEB +: 3] != 3'h0}};
	assign act      = ~(lvl ^ pin_pol);
	assign deb_lim  = deb_ticks(ctrl[CTRL_DEB +: 3]);

	// Debounce time base, one tick per filter unit
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tick_cnt <= 24'h00_0000;
			tick     <= 1'b0;
		end
		else if (ce_i)
		begin
			tick     <= (tick_cnt == 24'(DEB_TICK_CYCLES - 1));
			tick_cnt <= (tick_cnt == 24'(DEB_TICK_CYCLES - 1)) ?
			            24'h00_0000 : tick_cnt + 24'h00_0001;
		end
	end

	// Pin synchroniser and filter; time is accurate to one tick
	for (genvar k = 0; k < 5; k++)
	begin : g_pin
		logic        s1, s2, s3, stbl;
		logic [13:0] cnt;
		always_ff @(posedge clk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
			begin
				s1   <= 1'b0;
				s2   <= 1'b0;
				s3   <= 1'b0;
				stbl <= 1'b0;
				cnt  <= 14'h0000;
				lvl[k] <= 1'b0;
			end
			else if (ce_i)
			begin
				s1 <= pin_raw[k];
				s2 <= s1;
				s3 <= s2;
				if (s2 == s3)
					stbl <= s3;
				if (!filt_on[k] || stbl == lvl[k])
				begin
					lvl[k] <= stbl;
					cnt    <= 14'h0000;
				end
				else if (tick)
				begin
					if (cnt >= deb_lim - 14'h0001)
					begin
						lvl[k] <= stbl;
						cnt    <= 14'h0000;
					end
					else
						cnt <= cnt + 14'h0001;
				end
			end
		end
	end

	// Live monitor view, ramp ready is the inverse of ramping
	assign mon_live = {~rail_b_ramping_i, ~rail_a_ramping_i,
	                   rail_b_overcurrent_i, rail_a_overcurrent_i,
	                   thermal_shutdown_flag_i, thermal_warning_i,
	                   rail_b_in_range_i, rail_a_in_range_i};

	// Change detection
	assign new_in  = ({1'b0, io_supply_undervoltage_i & ~uv_prev, 1'b0,
	                  act & ~act_prev}) & VLD_IN_EVT;
	assign new_flt = {2'b00,
	                  mon_live[MON_OC_B:MON_OC_A]
	                  & ~mon_prev[MON_OC_B:MON_OC_A]
	                  & ~flt_mask[MON_OC_B:MON_OC_A],
	                  mon_live[3:2] & ~mon_prev[3:2],
	                  mon_prev[1:0] & ~mon_live[1:0]};

	// Previous values for edge detection
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mon_prev <= 8'h00;
			uv_prev  <= 1'b0;
			act_prev <= 5'h1F; // Reset act is all ones, avoids false edges
		end
		else if (ce_i)
		begin
			mon_prev <= mon_live;
			uv_prev  <= io_supply_undervoltage_i;
			act_prev <= act;
		end
	end

	// Event flags; arrivals in a clearing cycle wait one cycle
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			in_evt   <= RST_REG;
			flt_evt  <= RST_REG;
			in_hold  <= RST_REG;
			flt_hold <= RST_REG;
		end
		else if (ce_i)
		begin
			if (clr_in)
			begin
				in_evt  <= (in_evt & ~reg_wdata_i) | in_hold;
				in_hold <= new_in;
			end
			else
			begin
				in_evt  <= in_evt | new_in | in_hold;
				in_hold <= RST_REG;
			end
			if (clr_flt)
			begin
				flt_evt  <= (flt_evt & ~reg_wdata_i) | flt_hold;
				flt_hold <= new_flt;
			end
			else
			begin
				flt_evt  <= flt_evt | new_flt | flt_hold;
				flt_hold <= RST_REG;
			end
		end
	end

	// Interrupt, low while any unmasked flag is set
	assign irq_any = |((in_evt & ~in_mask) | (flt_evt & ~flt_mask));
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			interrupt_out_n_o <= 1'b1;
		else if (ce_i)
			interrupt_out_n_o <= ~irq_any;
	end

	// Register read; values sampled at the read strobe
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			reg_rdata_o  <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end
		else if (ce_i)
		begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i)
			begin
				case (reg_addr_i)
					ADR_IN_STAT:  reg_rdata_o <= {3'h0, lvl};
					ADR_MON_STAT: reg_rdata_o <= mon_live;
					ADR_IN_EVT:   reg_rdata_o <= in_evt;
					ADR_FLT_EVT:  reg_rdata_o <= flt_evt;
					ADR_IN_MASK:  reg_rdata_o <= in_mask;
					ADR_FLT_MASK: reg_rdata_o <= flt_mask;
					ADR_CTRL:     reg_rdata_o <= ctrl;
					ADR_CFG01:    reg_rdata_o <= cfg01;
					ADR_CFG23:    reg_rdata_o <= cfg23;
					ADR_CFG4:     reg_rdata_o <= cfg4;
					default:      reg_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// IO pin drivers; mode bit picks active or passive level
	assign v2 = cfg23[CFG_MODE_L] ? cfg23[CFG_POL_L] : ~cfg23[CFG_POL_L];
	assign v3 = cfg23[CFG_MODE_H] ? cfg23[CFG_POL_H] : ~cfg23[CFG_POL_H];
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			io_pin_2_o      <= 1'b0;
			io_pin_2_oe_n_o <= 1'b1;
			io_pin_3_o      <= 1'b0;
			io_pin_3_oe_n_o <= 1'b1;
			track_enable_o  <= 1'b0;
		end
		else if (ce_i)
		begin
			// Open drain only ever pulls low
			io_pin_2_o      <= (fn2 == FN_PP) & v2;
			io_pin_2_oe_n_o <= ~((fn2 == FN_PP) | ((fn2 == FN_OD) & ~v2));
			io_pin_3_o      <= (fn3 == FN_PP) & v3;
			io_pin_3_oe_n_o <= ~((fn3 == FN_PP) | ((fn3 == FN_OD) & ~v3));
			track_enable_o  <= (cfg01[CFG_FN_L +: 2] == FN_TRACK)
			                   & act[0];
		end
	end

	// Ramp step timers, one step of the set size per interval
	assign rail_ramp    = {rail_b_ramping_i, rail_a_ramping_i};
	assign slew_code[0] = ctrl[CTRL_SLA +: 2];
	assign slew_code[1] = ctrl[CTRL_SLB +: 2];
	for (genvar r = 0; r < 2; r++)
	begin : g_slew
		logic [9:0] cnt;
		always_ff @(posedge clk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
			begin
				cnt          <= 10'h000;
				rail_step[r] <= 1'b0;
			end
			else if (ce_i)
			begin
				if (!rail_ramp[r])
				begin
					cnt          <= 10'h000;
					rail_step[r] <= 1'b0;
				end
				else if (cnt >= slew_cyc(slew_code[r]) - 10'h001)
				begin
					cnt          <= 10'h000;
					rail_step[r] <= 1'b1;
				end
				else
				begin
					cnt          <= cnt + 10'h001;
					rail_step[r] <= 1'b0;
				end
			end
		end
	end
	assign rail_a_step_o = rail_step[0];
	assign rail_b_step_o = rail_step[1];

	// Checks
	a_irq_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i |=> interrupt_out_n_o == !$past(irq_any))
		else $error("interrupt does not follow unmasked flags");
	a_mask_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && ((in_evt & ~in_mask) == 8'h00)
		&& ((flt_evt & ~flt_mask) == 8'h00) |=> interrupt_out_n_o)
		else $error("masked flags raised interrupt");
	a_ready_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && reg_rd_i && reg_addr_i == ADR_MON_STAT
		|=> reg_rvalid_o && reg_rdata_o[7:6]
		== ~{$past(rail_b_ramping_i), $past(rail_a_ramping_i)})
		else $error("ramp ready wrong");
	a_status_live: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && reg_rd_i && reg_addr_i == ADR_MON_STAT
		|=> reg_rdata_o[5:0] == $past(mon_live[5:0]))
		else $error("status read not live");
	a_clear_exact: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && clr_flt && flt_hold == 8'h00
		|=> flt_evt == ($past(flt_evt) & ~$past(reg_wdata_i)))
		else $error("clear not exact");
	a_hold_post: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && clr_flt && new_flt != 8'h00 ##1 ce_i && !clr_flt
		|=> (flt_evt & $past(flt_hold)) == $past(flt_hold))
		else $error("held event lost");
	a_oc_blocked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && flt_mask[MON_OC_B] && !flt_evt[MON_OC_B]
		&& !flt_hold[MON_OC_B] |=> !flt_evt[MON_OC_B])
		else $error("masked overcurrent recorded");
	a_lock_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_en && in_lock && ctrl[CTRL_LOCK] |=> !locked_wr_o)
		else $error("locked write passed");
	a_lock_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_en && in_lock && !ctrl[CTRL_LOCK]
		|=> locked_wr_o && locked_addr_o == $past(reg_addr_i))
		else $error("unlocked write dropped");
	a_step_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && !rail_a_ramping_i |=> !rail_a_step_o)
		else $error("step without ramp");
	a_pp_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && fn3 == FN_PP |=> !io_pin_3_oe_n_o
		&& io_pin_3_o == $past(v3))
		else $error("push pull not driven");
	a_od_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && fn2 == FN_OD && v2 |=> io_pin_2_oe_n_o)
		else $error("open drain drove high");
endmodule
`default_nettype wire

// file: seg_host_model.sv
// Host-side register master model for the status and event block
`default_nettype none
module seg_host_model (
	// Clock
	input  wire logic       clk_i,
	// Register port towards the block
	output logic      [8:0] reg_addr_o,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_wdata_o,
	input  wire logic [7:0] reg_rdata_i,
	input  wire logic       reg_rvalid_i
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle bus at time zero
	initial
	begin
		reg_addr_o  = 9'h000;
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
		reg_wdata_o = 8'h00;
	end

	// One write strobe; lines are inverted afterwards so stale data never
	// looks like a fresh request
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_o  <= a;
		reg_wdata_o <= d;
		reg_wr_o    <= 1'b1;
		@(posedge clk_i);
		reg_wr_o    <= 1'b0;
		reg_addr_o  <= ~a;
		reg_wdata_o <= ~d;
	endtask

	// One read strobe, bounded wait for the valid flag
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		int n;
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_rd_o   <= 1'b1;
		@(posedge clk_i);
		reg_rd_o   <= 1'b0;
		reg_addr_o <= ~a;
		n = 0;
		#1;
		while (reg_rvalid_i !== 1'b1 && n < 4)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		d = reg_rdata_i;
	endtask

	// Clear an event register by writing back exactly what was read
	task automatic clr(input logic [8:0] a, output logic [7:0] v);
		rd(a, v);
		wr(a, v);
	endtask
endmodule
`default_nettype wire

// file: seg_pkg.sv
// Constants for the status, event and pin configuration block
`default_nettype none
package seg_pkg;
	// Register offsets
	localparam logic [8:0] ADR_IN_STAT  = 9'h050;
	localparam logic [8:0] ADR_MON_STAT = 9'h051;
	localparam logic [8:0] ADR_IN_EVT   = 9'h052;
	localparam logic [8:0] ADR_FLT_EVT  = 9'h053;
	localparam logic [8:0] ADR_IN_MASK  = 9'h054;
	localparam logic [8:0] ADR_FLT_MASK = 9'h055;
	localparam logic [8:0] ADR_CTRL     = 9'h056;
	localparam logic [8:0] ADR_CFG01    = 9'h058;
	localparam logic [8:0] ADR_CFG23    = 9'h059;
	localparam logic [8:0] ADR_CFG4     = 9'h05A;
	localparam logic [8:0] ADR_LOCK_LO  = 9'h0D0;
	localparam logic [8:0] ADR_LOCK_HI  = 9'h14F;
	// Implemented bits of each register, reserved bits read zero
	localparam logic [7:0] VLD_IN_STAT  = 8'h1F;
	localparam logic [7:0] VLD_IN_EVT   = 8'h5F;
	localparam logic [7:0] VLD_FLT_EVT  = 8'h3F;
	localparam logic [7:0] VLD_CFG4     = 8'h0F;
	localparam logic [7:0] RST_REG      = 8'h00;
	// Field positions
	localparam int CTRL_LOCK  = 7;
	localparam int CTRL_SLB   = 5;
	localparam int CTRL_SLA   = 3;
	localparam int CTRL_DEB   = 0;
	localparam int EVT_UV     = 6;
	localparam int MON_OC_B   = 5;
	localparam int MON_OC_A   = 4;
	localparam int CFG_MODE_L = 3;
	localparam int CFG_POL_L  = 2;
	localparam int CFG_FN_L   = 0;
	localparam int CFG_MODE_H = 7;
	localparam int CFG_POL_H  = 6;
	localparam int CFG_FN_H   = 4;
	// Pin function codes
	localparam logic [1:0] FN_IN    = 2'h0;
	localparam logic [1:0] FN_TRACK = 2'h1;
	localparam logic [1:0] FN_OD    = 2'h2;
	localparam logic [1:0] FN_PP    = 2'h3;
	// Timing
	localparam real CLK_PERIOD_NS = 4.0;
	localparam int  SLEW_STEP_MV  = 10;
	localparam real SLEW_T0_US    = 4.0;
	localparam real SLEW_T1_US    = 2.0;
	localparam real SLEW_T2_US    = 1.0;
	localparam real SLEW_T3_US    = 0.5;
	localparam logic [9:0] SLEW_C0 = 10'(int'(SLEW_T0_US*1000.0/CLK_PERIOD_NS));
	localparam logic [9:0] SLEW_C1 = 10'(int'(SLEW_T1_US*1000.0/CLK_PERIOD_NS));
	localparam logic [9:0] SLEW_C2 = 10'(int'(SLEW_T2_US*1000.0/CLK_PERIOD_NS));
	localparam logic [9:0] SLEW_C3 = 10'(int'(SLEW_T3_US*1000.0/CLK_PERIOD_NS));
	localparam real DEB_TICK_MS  = 0.1;
	localparam int  DEB_TICK_CYC = int'(DEB_TICK_MS*1.0e6/CLK_PERIOD_NS);
	localparam real DEB_T1_MS = 0.1;
	localparam real DEB_T2_MS = 1.0;
	localparam real DEB_T3_MS = 10.0;
	localparam real DEB_T4_MS = 50.0;
	localparam real DEB_T5_MS = 250.0;
	localparam real DEB_T6_MS = 500.0;
	localparam real DEB_T7_MS = 1000.0;
	localparam logic [13:0] DEB_K1 = 14'(int'(DEB_T1_MS/DEB_TICK_MS));
	localparam logic [13:0] DEB_K2 = 14'(int'(DEB_T2_MS/DEB_TICK_MS));
	localparam logic [13:0] DEB_K3 = 14'(int'(DEB_T3_MS/DEB_TICK_MS));
	localparam logic [13:0] DEB_K4 = 14'(int'(DEB_T4_MS/DEB_TICK_MS));
	localparam logic [13:0] DEB_K5 = 14'(int'(DEB_T5_MS/DEB_TICK_MS));
	localparam logic [13:0] DEB_K6 = 14'(int'(DEB_T6_MS/DEB_TICK_MS));
	localparam logic [13:0] DEB_K7 = 14'(int'(DEB_T7_MS/DEB_TICK_MS));
endpackage
`default_nettype wire

// file: tb.sv
// Self-checking bench for the status, event and pin configuration block
`default_nettype none
module tb import seg_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TICK = 4;
	logic       clk_i   = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [4:0] pins    = 5'h1F;
	logic [8:0] mon     = 9'h003;
	logic       ce      = 1'b1;
	logic [8:0] reg_addr, lk_addr, lk_a;
	logic [7:0] reg_wdata, reg_rdata, lk_wdata, lk_d, v;
	logic       reg_wr, reg_rd, reg_rvalid, lk_wr, track, irq_n;
	logic       io2_o, io2_oe_n, io3_o, io3_oe_n, io2_w, io3_w;
	logic       step_a, step_b, step_sel, sel_b;
	int         lk_cnt      = 0;
	int         failures    = 0;
	int         checks_done = 0;

	always #2 clk_i = ~clk_i;
	// A driving pin wins over the external pull-up level
	assign io2_w    = (io2_oe_n === 1'b0) ? io2_o : pins[2];
	assign io3_w    = (io3_oe_n === 1'b0) ? io3_o : pins[3];
	assign step_sel = sel_b ? step_b : step_a;

	seg_ctrl #(.DEB_TICK_CYCLES(TICK)) dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
		.reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
		.reg_rvalid_o(reg_rvalid), .locked_wr_o(lk_wr),
		.locked_addr_o(lk_addr), .locked_wdata_o(lk_wdata),
		.input_pin_0_i(pins[0]), .input_pin_1_i(pins[1]),
		.io_pin_2_i(io2_w), .io_pin_3_i(io3_w), .input_pin_4_i(pins[4]),
		.io_pin_2_o(io2_o), .io_pin_2_oe_n_o(io2_oe_n),
		.io_pin_3_o(io3_o), .io_pin_3_oe_n_o(io3_oe_n),
		.track_enable_o(track), .io_supply_undervoltage_i(mon[8]),
		.rail_a_ramping_i(mon[6]), .rail_b_ramping_i(mon[7]),
		.rail_a_overcurrent_i(mon[4]), .rail_b_overcurrent_i(mon[5]),
		.thermal_shutdown_flag_i(mon[3]), .thermal_warning_i(mon[2]),
		.rail_a_in_range_i(mon[0]), .rail_b_in_range_i(mon[1]),
		.rail_a_step_o(step_a), .rail_b_step_o(step_b),
		.interrupt_out_n_o(irq_n)
	);

	seg_host_model host (
		.clk_i(clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
		.reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata),
		.reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid)
	);

	// Count forwarded writes away from the launching edge
	always @(negedge clk_i)
		if (lk_wr === 1'b1)
		begin
			lk_cnt++;
			lk_a = lk_addr;
			lk_d = lk_wdata;
		end

	task automatic give_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic rchk(input logic [8:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		chk(16'(d), 16'(e));
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	task automatic t_reset();
		logic [8:0] ra [6] = '{ADR_IN_MASK, ADR_FLT_MASK, ADR_CTRL,
			ADR_CFG01, ADR_CFG23, ADR_CFG4};
		foreach (ra[i])
			rchk(ra[i], RST_REG);
		rchk(ADR_IN_EVT, 8'h00);
		rchk(ADR_FLT_EVT, 8'h00);
		chk(16'(irq_n), 16'h0001);
		host.wr(ADR_IN_STAT, 8'h00);
		rchk(ADR_IN_STAT, 8'h1F);
		rchk(9'h1F0, 8'h00);
		done("reset");
	endtask

	task automatic t_status();
		logic [7:0] p [2] = '{8'h6A, 8'h95};
		foreach (p[i])
		begin
			@(posedge clk_i) mon[7:0] <= p[i];
			tick(2);
			rchk(ADR_MON_STAT, {~p[i][7:6], p[i][5:0]});
		end
		@(posedge clk_i) mon <= 9'h003;
		tick(4);
		host.clr(ADR_FLT_EVT, v);
		rchk(ADR_FLT_EVT, 8'h00);
		done("status");
	endtask

	task automatic t_fault();
		@(posedge clk_i) mon <= 9'h03C;
		tick(3);
		rchk(ADR_FLT_EVT, 8'h3F);
		chk(16'(irq_n), 16'h0000);
		host.wr(ADR_FLT_EVT, 8'h0C);
		rchk(ADR_FLT_EVT, 8'h33);
		chk(16'(irq_n), 16'h0000);
		@(posedge clk_i) mon[2] <= 1'b0;
		tick(2);
		// New warning arrives in the very cycle of the clearing write
		fork
			host.wr(ADR_FLT_EVT, 8'h33);
			@(posedge clk_i) mon[2] <= 1'b1;
		join
		tick(2);
		rchk(ADR_FLT_EVT, 8'h04);
		host.clr(ADR_FLT_EVT, v);
		tick(4);
		chk(16'(irq_n), 16'h0001);
		@(posedge clk_i) mon <= 9'h003;
		tick(3);
		rchk(ADR_FLT_EVT, 8'h00);
		done("fault");
	endtask

	task automatic t_mask();
		host.wr(ADR_FLT_MASK, 8'hFF);
		rchk(ADR_FLT_MASK, 8'h3F);
		host.wr(ADR_IN_MASK, 8'hFF);
		rchk(ADR_IN_MASK, 8'h5F);
		@(posedge clk_i) mon <= 9'h037;
		tick(3);
		rchk(ADR_FLT_EVT, 8'h04);
		chk(16'(irq_n), 16'h0001);
		host.wr(ADR_FLT_MASK, 8'h00);
		tick(3);
		chk(16'(irq_n), 16'h0000);
		host.clr(ADR_FLT_EVT, v);
		host.wr(ADR_IN_MASK, 8'h00);
		@(posedge clk_i) mon <= 9'h003;
		done("mask");
	endtask

	task automatic t_pin_evt();
		host.wr(ADR_CFG01, 8'h40);
		host.wr(ADR_CFG4, 8'h04);
		@(posedge clk_i)
		begin
			pins[0] <= 1'b0;
			mon[8]  <= 1'b1;
		end
		tick(6);
		rchk(ADR_IN_EVT, 8'h53);
		rchk(ADR_IN_STAT, 8'h1E);
		chk(16'(irq_n), 16'h0000);
		host.wr(ADR_CFG01, 8'h00);
		host.wr(ADR_CFG4, 8'h00);
		@(posedge clk_i)
		begin
			pins[0] <= 1'b1;
			mon[8]  <= 1'b0;
		end
		tick(6);
		host.clr(ADR_IN_EVT, v);
		rchk(ADR_IN_EVT, 8'h00);
		done("pin events");
	endtask

	task automatic t_io_out();
		logic [7:0] c [5] = '{8'h33, 8'hBB, 8'hFF, 8'h22, 8'hAA};
		logic [1:0] e [5] = '{2'b10, 2'b00, 2'b10, 2'b01, 2'b00};
		logic [7:0] q [2] = '{8'h11, 8'h00};
		foreach (c[i])
		begin
			host.wr(ADR_CFG23, c[i]);
			tick(2);
			chk(16'({io2_o, io2_oe_n, io3_o, io3_oe_n}), 16'({e[i], e[i]}));
		end
		foreach (q[i])
		begin
			host.wr(ADR_CFG23, q[i]);
			tick(2);
			chk(16'({io2_oe_n, io3_oe_n}), 16'h0003);
		end
		tick(6);
		host.clr(ADR_IN_EVT, v);
		done("io outputs");
	endtask

	task automatic t_track();
		host.wr(ADR_CFG01, 8'h01);
		@(posedge clk_i) pins[0] <= 1'b0;
		tick(8);
		chk(16'(track), 16'h0001);
		@(posedge clk_i) pins[0] <= 1'b1;
		tick(8);
		chk(16'(track), 16'h0000);
		host.wr(ADR_CFG01, 8'h05);
		tick(3);
		chk(16'(track), 16'h0001);
		host.wr(ADR_CFG01, 8'h00);
		tick(3);
		chk(16'(track), 16'h0000);
		done("track");
	endtask

	task automatic t_lock();
		host.wr(9'h0D0, 8'h11);
		tick(2);
		chk(16'(lk_cnt), 16'd1);
		chk(16'({lk_a, lk_d}), 16'hD011);
		host.wr(9'h14F, 8'h22);
		host.wr(9'h0CF, 8'h01);
		host.wr(9'h150, 8'h02);
		tick(2);
		chk(16'(lk_cnt), 16'd2);
		host.wr(ADR_CTRL, 8'h80);
		rchk(ADR_CTRL, 8'h80);
		host.wr(9'h0D0, 8'h33);
		host.wr(9'h14F, 8'h34);
		tick(2);
		chk(16'(lk_cnt), 16'd2);
		host.wr(ADR_CTRL, 8'h00);
		host.wr(9'h100, 8'h44);
		tick(2);
		chk(16'(lk_cnt), 16'd3);
		chk(16'(lk_a), 16'h0100);
		done("lock");
	endtask

	// Cycles until the selected step pulse, bounded
	task automatic wait_step(output int n);
		n = 0;
		do
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		while (step_sel !== 1'b1 && n < 2100);
	endtask

	task automatic t_slew();
		int n;
		for (int c = 0; c < 5; c++)
		begin
			sel_b = (c == 4);
			host.wr(ADR_CTRL, (c < 4) ? 8'(c << 3) : 8'h60);
			@(posedge clk_i) mon[(c < 4) ? 6 : 7] <= 1'b1;
			wait_step(n);
			wait_step(n);
			chk(16'(n), (c < 4) ? 16'(1000 >> c) : 16'd125);
			@(posedge clk_i) mon[7:6] <= 2'b00;
			tick(4);
		end
		done("slew");
	endtask

	task automatic t_debounce();
		int         kk [5] = '{0, 1, 10, 100, 500};
		logic [7:0] d;
		host.wr(ADR_CFG01, 8'h80);
		foreach (kk[i])
		begin
			host.wr(ADR_CTRL, 8'(i));
			@(posedge clk_i) pins[1] <= 1'b0;
			if (kk[i] > 1)
			begin
				tick(TICK * kk[i] - 6);
				host.rd(ADR_IN_STAT, d);
				chk(16'(d[1]), 16'h0001);
			end
			tick((kk[i] > 1) ? 12 : TICK * kk[i] + 10);
			host.rd(ADR_IN_STAT, d);
			chk(16'(d[1]), 16'h0000);
			@(posedge clk_i) pins[1] <= 1'b1;
			tick(TICK * kk[i] + 20);
		end
		// Mode bit off bypasses even a long filter time
		host.wr(ADR_CFG01, 8'h00);
		host.wr(ADR_CTRL, 8'h04);
		@(posedge clk_i) pins[1] <= 1'b0;
		tick(6);
		host.rd(ADR_IN_STAT, d);
		chk(16'(d[1]), 16'h0000);
		done("debounce");
	endtask

	// A write strobe while the enable is low must leave state untouched
	task automatic t_ce();
		@(posedge clk_i) ce <= 1'b0;
		host.wr(ADR_FLT_MASK, 8'h3F);
		@(posedge clk_i) ce <= 1'b1;
		rchk(ADR_FLT_MASK, 8'h00);
		done("clock enable");
	endtask

	initial
	begin
		sel_b = 1'b0;
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		t_reset();
		t_status();
		t_fault();
		t_mask();
		t_pin_evt();
		t_io_out();
		t_track();
		t_lock();
		t_slew();
		t_debounce();
		t_ce();
		give_verdict();
	end

	// Run is about 10000 cycles; cut a hang off well beyond that
	initial
	begin
		#400000;
		failures++;
		give_verdict();
	end
endmodule
`default_nettype wire
